// file: hdl/rsio_pkg.sv
// constants for the relay status input and output logic
package rsio_pkg;
	localparam int CLK_NS = 10;
	localparam int SAMPLE_NS_50 = 2500000;
	localparam int SAMPLE_NS_60 = 2083333;
	localparam int SAMPLE_CYC_50 = SAMPLE_NS_50 / CLK_NS;
	localparam int SAMPLE_CYC_60 = SAMPLE_NS_60 / CLK_NS;
	localparam int MS_NS = 1000000;
	localparam int MS_CYC = MS_NS / CLK_NS;
	localparam int SEC_MS = 1000;
	localparam int FLASH_MS = 250;
	localparam logic [3:0] FILT_MAX = 4'h8;
	localparam logic [6:0] HOLD_MS = 7'h3c;
	localparam logic [6:0] AR_MS = 7'h64;
	localparam int N_OPTO = 5;
	localparam int OPTO_INH = 0;
	localparam int OPTO_PIT = 1;
	localparam int OPTO_IT = 2;
	localparam int OPTO_RST = 3;
	localparam int OPTO_SYNC = 4;
	localparam int N_OUT = 8;
	localparam int OUT_ANY = 3;
	localparam int OUT_IT = 7;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_TIME = 8'h08;
	localparam int CTRL_POLE = 0;
	localparam int CTRL_AR3 = 1;
	localparam int CTRL_SYNC_LO = 2;
	localparam int CTRL_F60 = 5;
	localparam logic [2:0] SYNC_RST = 3'h0;
	localparam logic [31:0] SYNC_5M = 32'h0000012c;
	localparam logic [31:0] SYNC_10M = 32'h00000258;
	localparam logic [31:0] SYNC_15M = 32'h00000384;
	localparam logic [31:0] SYNC_30M = 32'h00000708;
	localparam logic [31:0] SYNC_60M = 32'h00000e10;
endpackage : rsio_pkg

// file: hdl/rsio_core.sv
// status input filters, inhibit handshake and trip output logic
`timescale 1ns/1ps
module rsio_core #(
	parameter int SAMPLE_CYC_50 = rsio_pkg::SAMPLE_CYC_50,
	parameter int SAMPLE_CYC_60 = rsio_pkg::SAMPLE_CYC_60,
	parameter int MS_CYC = rsio_pkg::MS_CYC
) (
	input wire logic sys_clk, // 100 MHz clock
	input wire logic rst_b, // async reset, low
	input wire logic [7:0] paddr, // apb address
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic [4:0] optoIn, // opto pins
	input wire logic [2:0] diffPhase, // local phases operated
	input wire logic diffGround, // local fault involves ground
	input wire logic [2:0] rxTripPhase, // received transfer trip
	input wire logic rxTripGround, // received trip is ground
	input wire logic rxInhibit, // received remote inhibit
	input wire logic rxIntertrip, // received intertrip
	input wire logic rxPermIt, // received permissive intertrip
	input wire logic alarmIn, // alarm request
	output logic txInhibit, // inhibit bit to send
	output logic txIntertrip, // intertrip bit to send
	output logic txPermIt, // permissive bit to send
	output logic trip_phase_a, // trip group a
	output logic trip_phase_b, // trip group b
	output logic trip_phase_c, // trip group c
	output logic anyTrip, // any-trip output
	output logic [2:0] phase_operated_flags, // per-phase operated
	output logic intertripOut, // intertrip output
	output logic blockArOut, // block auto-reclose
	output logic alarmOut, // alarm output
	output logic oosLed, // out-of-service led
	output logic tripLed, // trip led
	output logic alarmLed, // alarm led
	output logic dispClear, // clear alarm display pulse
	output logic [31:0] calSec // calendar seconds
);
	typedef struct packed {
		logic [4:0] s1;
		logic [4:0] s2;
		logic [4:0][3:0] fcnt;
		logic [4:0] fltPrev;
		logic [17:0] sdiv;
		logic [16:0] mdiv;
		logic [9:0] secCnt;
		logic [7:0] flashCnt;
		logic flash;
		logic [3:0] relCnt;
		logic [7:0] out;
		logic [7:0][6:0] hold;
		logic ar;
		logic [6:0] arCnt;
		logic tripLed;
		logic alarmLed;
		logic dispClr;
		logic singlePole;
		logic arOn3ph;
		logic freq60;
		logic [2:0] syncSel;
		logic [31:0] sec;
		logic [31:0] rdata;
		logic slverr;
	} rsio_state_s;

	rsio_state_s r_reg;
	rsio_state_s r_next;
	logic sTick, mTick, secTick, inhAcc, supp, pit, gnd, anyCond;
	logic rstEdge, syncEdge, arCond, apbWr;
	logic [4:0] flt;
	logic [2:0] phaseOp, routed;
	logic [7:0] cond;
	logic [31:0] iv, remv, snapped;

	////////////////////////////////////////////////////////////////////////
	function automatic logic regHit(input logic [7:0] a);
		regHit = (a == rsio_pkg::REG_CTRL) || (a == rsio_pkg::REG_STAT) ||
			(a == rsio_pkg::REG_TIME);
	endfunction : regHit

	function automatic logic [31:0] syncSecs(input logic [2:0] sel);
		case (sel)
			3'h1: syncSecs = rsio_pkg::SYNC_10M;
			3'h2: syncSecs = rsio_pkg::SYNC_15M;
			3'h3: syncSecs = rsio_pkg::SYNC_30M;
			3'h4: syncSecs = rsio_pkg::SYNC_60M;
			default: syncSecs = rsio_pkg::SYNC_5M;
		endcase
	endfunction : syncSecs

	////////////////////////////////////////////////////////////////////////
	// time bases: sample strobe per mains rate, millisecond and second
	assign sTick = r_reg.sdiv >= (r_reg.freq60 ? 18'(SAMPLE_CYC_60 - 1) :
		18'(SAMPLE_CYC_50 - 1));
	assign mTick = r_reg.mdiv == 17'(MS_CYC - 1);
	assign secTick = mTick && r_reg.secCnt == 10'(rsio_pkg::SEC_MS - 1);

	genvar gi;
	generate
		for (gi = 0; gi < rsio_pkg::N_OPTO; gi++) begin : g_flt
			assign flt[gi] = r_reg.fcnt[gi] == rsio_pkg::FILT_MAX;
		end
	endgenerate

	assign inhAcc = flt[rsio_pkg::OPTO_INH];
	assign supp = inhAcc || r_reg.relCnt != 4'h0 || rxInhibit;
	assign rstEdge = flt[rsio_pkg::OPTO_RST] &&
		!r_reg.fltPrev[rsio_pkg::OPTO_RST];
	assign syncEdge = flt[rsio_pkg::OPTO_SYNC] &&
		!r_reg.fltPrev[rsio_pkg::OPTO_SYNC];

	// trip routing
	assign pit = rxPermIt;
	assign phaseOp = diffPhase | rxTripPhase;
	assign gnd = diffGround || rxTripGround;
	assign anyCond = (|phaseOp) || pit;
	assign routed = (r_reg.singlePole && !pit && gnd && $onehot(phaseOp)) ?
		phaseOp : {3{anyCond}};
	assign cond = {rxIntertrip, diffPhase, anyCond, routed};
	assign arCond = pit || (r_reg.arOn3ph && (&phaseOp));
	assign apbWr = psel && penable && pwrite && regHit(paddr);

	// snap to nearest multiple of the sync interval
	assign iv = syncSecs(r_reg.syncSel);
	assign remv = r_reg.sec % iv;
	assign snapped = ({remv[30:0], 1'b0} >= iv) ? r_reg.sec + (iv - remv) :
		r_reg.sec - remv;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		r_next = r_reg;
		r_next.s1 = optoIn;
		r_next.s2 = r_reg.s1;
		r_next.fltPrev = flt;
		r_next.sdiv = sTick ? 18'h00000 : r_reg.sdiv + 18'h00001;
		r_next.mdiv = mTick ? 17'h00000 : r_reg.mdiv + 17'h00001;
		if (secTick) begin
			r_next.secCnt = 10'h000;
		end else if (mTick) begin
			r_next.secCnt = r_reg.secCnt + 10'h001;
		end
		// eight-sample filters, restart on any inactive sample
		for (int i = 0; i < rsio_pkg::N_OPTO; i++) begin
			if (sTick) begin
				if (!r_reg.s2[i]) begin
					r_next.fcnt[i] = 4'h0;
				end else if (r_reg.fcnt[i] != rsio_pkg::FILT_MAX) begin
					r_next.fcnt[i] = r_reg.fcnt[i] + 4'h1;
				end
			end
		end
		// release delay after inhibit withdrawn
		if (inhAcc) begin
			r_next.relCnt = rsio_pkg::FILT_MAX;
		end else if (sTick && r_reg.relCnt != 4'h0) begin
			r_next.relCnt = r_reg.relCnt - 4'h1;
		end
		// outputs with minimum hold, immediate drop after it
		for (int i = 0; i < rsio_pkg::N_OUT; i++) begin
			if (supp) begin
				r_next.out[i] = 1'b0;
				r_next.hold[i] = 7'h00;
			end else if (cond[i] && !r_reg.out[i]) begin
				r_next.out[i] = 1'b1;
				r_next.hold[i] = rsio_pkg::HOLD_MS;
			end else begin
				if (mTick && r_reg.hold[i] != 7'h00) begin
					r_next.hold[i] = r_reg.hold[i] - 7'h01;
				end
				r_next.out[i] = r_reg.out[i] &&
					(cond[i] || r_reg.hold[i] != 7'h00);
			end
		end
		// auto-reclose block with drop-off extension
		if (supp) begin
			r_next.ar = 1'b0;
			r_next.arCnt = 7'h00;
		end else if (arCond) begin
			r_next.ar = 1'b1;
			r_next.arCnt = rsio_pkg::AR_MS;
		end else if (r_reg.ar) begin
			if (r_reg.arCnt == 7'h00) begin
				r_next.ar = 1'b0;
			end else if (mTick) begin
				r_next.arCnt = r_reg.arCnt - 7'h01;
			end
		end
		// flash for remote inhibit
		if (mTick) begin
			if (r_reg.flashCnt == 8'(rsio_pkg::FLASH_MS - 1)) begin
				r_next.flashCnt = 8'h00;
				r_next.flash = !r_reg.flash;
			end else begin
				r_next.flashCnt = r_reg.flashCnt + 8'h01;
			end
		end
		// indicators: a new event wins over the reset
		r_next.dispClr = rstEdge;
		r_next.tripLed = (r_reg.tripLed && !rstEdge) ||
			r_reg.out[rsio_pkg::OUT_ANY] || r_reg.out[rsio_pkg::OUT_IT];
		r_next.alarmLed = (r_reg.alarmLed && !rstEdge) || alarmOut;
		// calendar seconds
		if (syncEdge) begin
			r_next.sec = snapped;
		end else if (secTick) begin
			r_next.sec = r_reg.sec + 32'h00000001;
		end
		// apb slave, zero wait states
		if (psel && !penable) begin
			r_next.slverr = !regHit(paddr);
			case (paddr)
				rsio_pkg::REG_CTRL: r_next.rdata = {26'h0000000, r_reg.freq60,
					r_reg.syncSel, r_reg.arOn3ph, r_reg.singlePole};
				rsio_pkg::REG_STAT: r_next.rdata = {20'h00000, r_reg.ar,
					r_reg.out, rxInhibit, r_reg.relCnt != 4'h0, inhAcc};
				rsio_pkg::REG_TIME: r_next.rdata = r_reg.sec;
				default: r_next.rdata = 32'h00000000;
			endcase
		end
		if (apbWr && paddr == rsio_pkg::REG_CTRL) begin
			r_next.singlePole = pwdata[rsio_pkg::CTRL_POLE];
			r_next.arOn3ph = pwdata[rsio_pkg::CTRL_AR3];
			r_next.syncSel = pwdata[rsio_pkg::CTRL_SYNC_LO +: 3];
			r_next.freq60 = pwdata[rsio_pkg::CTRL_F60];
		end
		if (apbWr && paddr == rsio_pkg::REG_TIME) begin
			r_next.sec = pwdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			r_reg <= '0;
			r_reg.syncSel <= rsio_pkg::SYNC_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign prdata = r_reg.rdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && r_reg.slverr;
	assign txInhibit = inhAcc;
	assign txIntertrip = flt[rsio_pkg::OPTO_IT];
	assign txPermIt = flt[rsio_pkg::OPTO_PIT];
	assign trip_phase_a = r_reg.out[0];
	assign trip_phase_b = r_reg.out[1];
	assign trip_phase_c = r_reg.out[2];
	assign anyTrip = r_reg.out[rsio_pkg::OUT_ANY];
	assign phase_operated_flags = r_reg.out[6:4];
	assign intertripOut = r_reg.out[rsio_pkg::OUT_IT];
	assign blockArOut = r_reg.ar;
	assign alarmOut = alarmIn && !supp;
	assign oosLed = inhAcc || (rxInhibit && r_reg.flash);
	assign tripLed = r_reg.tripLed;
	assign alarmLed = r_reg.alarmLed;
	assign dispClear = r_reg.dispClr;
	assign calSec = r_reg.sec;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence s_inh_drop;
		$fell(inhAcc);
	endsequence
	sequence s_rel_loaded;
		r_reg.relCnt == rsio_pkg::FILT_MAX && supp;
	endsequence

	property p_inh_accept;
		$rose(inhAcc) |-> $past(r_reg.s2[rsio_pkg::OPTO_INH]) &&
			$past(r_reg.fcnt[rsio_pkg::OPTO_INH]) == rsio_pkg::FILT_MAX - 4'h1;
	endproperty
	a_inh_accept: assert property (p_inh_accept)
		else $error("inhibit accepted early");

	property p_inh_release;
		s_inh_drop |-> s_rel_loaded;
	endproperty
	a_inh_release: assert property (p_inh_release)
		else $error("release delay not loaded");

	property p_supp_out;
		supp |=> r_reg.out == 8'h00 && !r_reg.ar;
	endproperty
	a_supp_out: assert property (p_supp_out)
		else $error("output while suppressed");

	property p_tx_inh;
		inhAcc |-> txInhibit && oosLed && !alarmOut;
	endproperty
	a_tx_inh: assert property (p_tx_inh)
		else $error("inhibit not signalled");

	property p_no_alarm;
		supp |-> !alarmOut;
	endproperty
	a_no_alarm: assert property (p_no_alarm)
		else $error("alarm during inhibit");

	property p_rst_led;
		rstEdge && !r_reg.out[rsio_pkg::OUT_ANY] &&
			!r_reg.out[rsio_pkg::OUT_IT] && !alarmOut |=>
			!tripLed && !alarmLed && dispClear;
	endproperty
	a_rst_led: assert property (p_rst_led)
		else $error("indicators not cleared");

	property p_single;
		r_reg.singlePole && !pit && gnd && $onehot(phaseOp) |->
			routed == phaseOp;
	endproperty
	a_single: assert property (p_single)
		else $error("single-pole routing wrong");

	property p_three;
		!r_reg.singlePole |-> routed == {3{anyCond}};
	endproperty
	a_three: assert property (p_three)
		else $error("three-pole routing wrong");

	property p_pit;
		pit |-> routed == 3'h7 && anyCond && cond[6:4] == diffPhase;
	endproperty
	a_pit: assert property (p_pit)
		else $error("permissive intertrip routing wrong");

	property p_it;
		rxIntertrip && !supp |=> intertripOut;
	endproperty
	a_it: assert property (p_it)
		else $error("intertrip output missing");

	property p_min_hold;
		$fell(anyTrip) && !$past(supp) |-> $past(r_reg.hold[rsio_pkg::OUT_ANY])
			== 7'h00;
	endproperty
	a_min_hold: assert property (p_min_hold)
		else $error("trip dropped before hold time");

	property p_drop;
		anyTrip && !cond[rsio_pkg::OUT_ANY] &&
			r_reg.hold[rsio_pkg::OUT_ANY] == 7'h00 |=> !anyTrip;
	endproperty
	a_drop: assert property (p_drop)
		else $error("trip did not reset");

	property p_ar_ext;
		$fell(blockArOut) && !$past(supp) |-> $past(r_reg.arCnt) == 7'h00 &&
			!$past(arCond);
	endproperty
	a_ar_ext: assert property (p_ar_ext)
		else $error("auto-reclose block dropped early");

	property p_ar_sel;
		!r_reg.arOn3ph && !pit |-> !arCond;
	endproperty
	a_ar_sel: assert property (p_ar_sel)
		else $error("auto-reclose block on wrong cause");

	property p_sync;
		syncEdge && !apbWr |=> (calSec % $past(iv)) == 32'h00000000;
	endproperty
	a_sync: assert property (p_sync)
		else $error("calendar not snapped");
endmodule : rsio_core

// file: bench/rsio_remote_model.sv
// behavioural remote relay exchanging message bits with the block
`timescale 1ns/1ps
module rsio_remote_model (
	input wire logic sys_clk, // clock
	input wire logic rst_b, // async reset, low
	input wire logic txInhibit, // inhibit bit sent to us
	input wire logic txIntertrip, // intertrip bit sent to us
	input wire logic cmdInhibit, // bench: remote end inhibited
	input wire logic cmdIntertrip, // bench: remote sends intertrip
	input wire logic cmdPermIt, // bench: remote sends permissive
	input wire logic [2:0] cmdTrip, // bench: transfer trip phases
	input wire logic cmdGround, // bench: transfer trip is ground
	output logic rxInhibit, // received inhibit bit
	output logic rxIntertrip, // received intertrip
	output logic rxPermIt, // received permissive
	output logic [2:0] rxTripPhase, // received trip phases
	output logic rxTripGround, // received ground flag
	output logic seenInhibit, // remote saw inhibit bit
	output logic seenIntertrip // remote energises intertrip
);
	// one message of latency each way
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			{rxInhibit, rxIntertrip, rxPermIt} <= 3'h0;
			{rxTripPhase, rxTripGround} <= 4'h0;
			{seenInhibit, seenIntertrip} <= 2'h0;
		end else begin
			rxInhibit <= cmdInhibit;
			rxIntertrip <= cmdIntertrip;
			rxPermIt <= cmdPermIt;
			rxTripPhase <= cmdTrip;
			rxTripGround <= cmdGround;
			seenInhibit <= txInhibit;
			seenIntertrip <= txIntertrip;
		end
	end
endmodule : rsio_remote_model

// file: bench/rsio_core_tb.sv
// self-checking testbench of the status input and trip output logic
`timescale 1ns/1ps
module rsio_core_tb;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [2:0] dp;
		logic dg;
		logic [2:0] rp;
		logic rg;
		logic pit;
		logic [7:0] exp;
	} rsio_row_s;
	localparam int LIMIT = 30000;
	logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, calSec, rd;
	logic [4:0] optoIn;
	logic [2:0] diffPhase, rxTripPhase, cmdTrip, phase_operated_flags;
	logic diffGround, rxTripGround, rxInhibit, rxIntertrip, rxPermIt, er;
	logic alarmIn, txInhibit, txIntertrip, txPermIt, anyTrip, intertripOut;
	logic trip_phase_a, trip_phase_b, trip_phase_c, blockArOut, alarmOut;
	logic oosLed, tripLed, alarmLed, dispClear, seenInhibit, seenIntertrip;
	logic cmdInhibit, cmdIntertrip, cmdPermIt, cmdGround;
	logic [15:0] cnt;
	logic [31:0] ivs [5];
	int bad_count, cmp_count, cyc;
	rsio_row_s rows [7];
	rsio_core #(.SAMPLE_CYC_50(16), .SAMPLE_CYC_60(13), .MS_CYC(4)) u_dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.optoIn(optoIn), .diffPhase(diffPhase), .diffGround(diffGround),
		.rxTripPhase(rxTripPhase), .rxTripGround(rxTripGround),
		.rxInhibit(rxInhibit), .rxIntertrip(rxIntertrip),
		.rxPermIt(rxPermIt), .alarmIn(alarmIn), .txInhibit(txInhibit),
		.txIntertrip(txIntertrip), .txPermIt(txPermIt),
		.trip_phase_a(trip_phase_a), .trip_phase_b(trip_phase_b),
		.trip_phase_c(trip_phase_c), .anyTrip(anyTrip),
		.phase_operated_flags(phase_operated_flags),
		.intertripOut(intertripOut), .blockArOut(blockArOut),
		.alarmOut(alarmOut), .oosLed(oosLed), .tripLed(tripLed),
		.alarmLed(alarmLed), .dispClear(dispClear), .calSec(calSec));
	rsio_remote_model u_remote (
		.sys_clk(sys_clk), .rst_b(rst_b), .txInhibit(txInhibit),
		.txIntertrip(txIntertrip), .cmdInhibit(cmdInhibit),
		.cmdIntertrip(cmdIntertrip), .cmdPermIt(cmdPermIt),
		.cmdTrip(cmdTrip), .cmdGround(cmdGround), .rxInhibit(rxInhibit),
		.rxIntertrip(rxIntertrip), .rxPermIt(rxPermIt),
		.rxTripPhase(rxTripPhase), .rxTripGround(rxTripGround),
		.seenInhibit(seenInhibit), .seenIntertrip(seenIntertrip));
	////////////////////////////////////////////////////////////////////////
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			bad_count++;
			stop_test();
		end
	end
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	task chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task stop_test;
		$display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////////////////
	initial begin
		rows = '{'{32'h1, 3'h1, 1'h1, 3'h0, 1'h0, 1'h0, 8'h32},
			'{32'h1, 3'h3, 1'h0, 3'h0, 1'h0, 1'h0, 8'hf6},
			'{32'h0, 3'h2, 1'h1, 3'h0, 1'h0, 1'h0, 8'hf4},
			'{32'h1, 3'h0, 1'h0, 3'h4, 1'h1, 1'h0, 8'h90},
			'{32'h1, 3'h0, 1'h0, 3'h0, 1'h0, 1'h1, 8'hf1},
			'{32'h3, 3'h7, 1'h0, 3'h0, 1'h0, 1'h0, 8'hff},
			'{32'h1, 3'h7, 1'h0, 3'h0, 1'h0, 1'h0, 8'hfe}};
		ivs = '{rsio_pkg::SYNC_5M, rsio_pkg::SYNC_10M, rsio_pkg::SYNC_15M,
			rsio_pkg::SYNC_30M, rsio_pkg::SYNC_60M};
		{sys_clk, rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
		{optoIn, diffPhase, diffGround, alarmIn, cmdTrip, cmdGround} = '0;
		{cmdInhibit, cmdIntertrip, cmdPermIt} = '0;
		tick(12);
		rst_b <= 1'b1;
		apb(1'b0, rsio_pkg::REG_CTRL, 32'h0);
		chk({er, rd}, 33'h0);
		apb(1'b0, rsio_pkg::REG_STAT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, rsio_pkg::REG_CTRL, 32'h23);
		apb(1'b0, rsio_pkg::REG_CTRL, 32'h0);
		chk(rd, 32'h23);
		apb(1'b1, 8'h0c, 32'hffffffff);
		chk(er, 1'b1);
		apb(1'b0, 8'h0c, 32'h0);
		chk({er, rd}, 33'h100000000);
		$display("registers test done");
		foreach (rows[i]) begin
			apb(1'b1, rsio_pkg::REG_CTRL, rows[i].ctrl);
			diffPhase <= rows[i].dp;
			diffGround <= rows[i].dg;
			cmdTrip <= rows[i].rp;
			cmdGround <= rows[i].rg;
			cmdPermIt <= rows[i].pit;
			tick(4);
			chk({trip_phase_c, trip_phase_b, trip_phase_a, anyTrip,
				phase_operated_flags, blockArOut}, rows[i].exp);
			{diffPhase, diffGround, cmdTrip, cmdGround, cmdPermIt} <= '0;
			tick(450);
		end
		$display("routing table test done");
		optoIn <= 5'h01;
		tick(100);
		chk(txInhibit, 1'b0);
		tick(50);
		chk({txInhibit, oosLed, seenInhibit}, 3'h7);
		apb(1'b0, rsio_pkg::REG_STAT, 32'h0);
		chk(rd, 32'h3);
		diffPhase <= 3'h1;
		alarmIn <= 1'b1;
		tick(4);
		chk({trip_phase_a, anyTrip, alarmOut}, 3'h0);
		optoIn <= 5'h00;
		tick(100);
		chk({anyTrip, alarmOut}, 2'h0);
		tick(70);
		chk({anyTrip, alarmOut}, 2'h3);
		{diffPhase, alarmIn} <= '0;
		tick(260);
		cmdInhibit <= 1'b1;
		tick(3);
		diffPhase <= 3'h1;
		cnt = 16'h0;
		repeat (2100) begin
			@(posedge sys_clk);
			cnt += oosLed;
		end
		chk(anyTrip, 1'b0);
		chk(cnt > 16'h0 && cnt < 16'h0834, 1'b1);
		cmdInhibit <= 1'b0;
		tick(4);
		chk(anyTrip, 1'b1);
		diffPhase <= 3'h0;
		tick(260);
		$display("inhibit test done");
		diffPhase <= 3'h2;
		tick(1);
		diffPhase <= 3'h0;
		tick(200);
		chk({anyTrip, phase_operated_flags}, 4'ha);
		tick(60);
		chk({anyTrip, phase_operated_flags}, 4'h0);
		cmdIntertrip <= 1'b1;
		tick(1);
		cmdIntertrip <= 1'b0;
		tick(3);
		chk(intertripOut, 1'b1);
		tick(200);
		chk(intertripOut, 1'b1);
		tick(60);
		chk(intertripOut, 1'b0);
		cmdPermIt <= 1'b1;
		tick(10);
		cmdPermIt <= 1'b0;
		tick(380);
		chk(blockArOut, 1'b1);
		tick(30);
		chk(blockArOut, 1'b0);
		$display("hold test done");
		chk(tripLed, 1'b1);
		optoIn <= 5'h08;
		tick(80);
		optoIn <= 5'h00;
		tick(40);
		chk(tripLed, 1'b1);
		optoIn <= 5'h08;
		cnt = 16'h0;
		repeat (180) begin
			@(posedge sys_clk);
			cnt += dispClear;
		end
		optoIn <= 5'h00;
		tick(2);
		chk({cnt, tripLed, alarmLed}, 18'h4);
		optoIn <= 5'h06;
		tick(150);
		chk({txIntertrip, txPermIt, seenIntertrip}, 3'h7);
		optoIn <= 5'h00;
		tick(20);
		chk(txIntertrip, 1'b0);
		$display("indication test done");
		for (int k = 0; k < 5; k++) begin
			for (int j = 0; j < 2; j++) begin
				apb(1'b1, rsio_pkg::REG_CTRL, (k << 2) | ((k / 4) << 5));
				apb(1'b1, rsio_pkg::REG_TIME, ivs[k] + ivs[k] / 2 - 2 + 2 * j);
				optoIn <= 5'h10;
				tick(160);
				optoIn <= 5'h00;
				tick(20);
				apb(1'b0, rsio_pkg::REG_TIME, 32'h0);
				chk(rd >= ivs[k] * (1 + j) && rd <= ivs[k] * (1 + j) + 1,
					1'b1);
			end
		end
		$display("sync test done");
		// reset in mid-run while a trip is standing
		diffPhase <= 3'h1;
		tick(4);
		rst_b <= 1'b0;
		tick(2);
		chk({anyTrip, tripLed, blockArOut, calSec}, 35'h0);
		rst_b <= 1'b1;
		tick(3);
		chk({anyTrip, trip_phase_a, phase_operated_flags}, 5'h19);
		diffPhase <= 3'h0;
		$display("reset test done");
		stop_test();
	end
endmodule : rsio_core_tb
